// File: rcf_chan_route.sv
// Channel router: turns frame type and enables into a channel mask.
// Assumes frame type flags are valid with the route strobe.
`timescale 1ns/1ps
`default_nettype none
module rcf_chan_route #(
  parameter int NUM_CHAN = 8
) (
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  input wire logic route_i,
  input wire logic is_unicast_i,
  input wire logic [2:0] uni_chan_i,
  input wire logic is_mcast_match_i,
  input wire logic [NUM_CHAN-1:0] uni_en_i,
  input wire logic [2:0] mult_ch_i,
  input wire logic mult_en_i,
  output logic [NUM_CHAN-1:0] deliver_o,
  output logic drop_o
);
  import rcf_pkg::*;

  // A 3-bit channel number reaches exactly eight channels
  if (NUM_CHAN != 8) begin : g_bad_chan
    $error("NUM_CHAN must be 8 for a 3-bit channel select");
  end

  typedef struct packed {
    logic [NUM_CHAN-1:0] deliver;
    logic drop;
  } rcf_rt_state_t;

  rcf_rt_state_t st_reg;
  rcf_rt_state_t st_next;

  // Decode a channel number to a one-hot mask
  function automatic logic [NUM_CHAN-1:0] chan_onehot(input logic [2:0] ch);
    chan_onehot = '0;
    chan_onehot[ch] = 1'b1;
  endfunction

  // ------------------------------------------------------------
  // Routing decision
  // ------------------------------------------------------------
  always_comb begin
    st_next.deliver = '0;
    st_next.drop = 1'b0;
    if (route_i) begin
      if (is_unicast_i) begin
        // Unicast passes only to an enabled channel
        st_next.deliver = chan_onehot(uni_chan_i) & uni_en_i; // [R12]
      end else if (is_mcast_match_i && mult_en_i) begin
        st_next.deliver = chan_onehot(mult_ch_i); // [R01] [R02]
      end
      st_next.drop = (st_next.deliver == '0);
    end
  end

  // State register
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      st_reg <= '0;
    end else begin
      st_reg <= st_next;
    end
  end

  assign deliver_o = st_reg.deliver;
  assign drop_o = st_reg.drop;

  a_mcast_gate: assert property ( // [R02]
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    route_i && !is_unicast_i && !mult_en_i |=> deliver_o == '0)
    else $error("multicast delivered while disabled");

  a_mcast_chan: assert property ( // [R01]
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    route_i && !is_unicast_i && is_mcast_match_i && mult_en_i
      |=> deliver_o == (1 << $past(mult_ch_i)))
    else $error("multicast sent to wrong channel");

  a_uni_gate: assert property ( // [R12]
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    route_i && is_unicast_i && !uni_en_i[uni_chan_i] |=> drop_o)
    else $error("unicast delivered to disabled channel");

endmodule
`default_nettype wire

// File: rcf_len_class.sv
// Frame length classifier: long, oversized or jabber.
// Assumes the end-of-frame strobe arrives with the final byte count.
`timescale 1ns/1ps
`default_nettype none
module rcf_len_class (
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  input wire logic eof_i,
  input wire logic [15:0] byte_count_i,
  input wire logic err_i,
  input wire logic [15:0] max_len_i,
  output logic valid_o,
  output logic long_o,
  output rcf_pkg::rcf_class_t class_o
);
  import rcf_pkg::*;

  typedef struct packed {
    logic valid;
    logic long_frm;
    rcf_class_t cls;
  } rcf_lc_state_t;

  rcf_lc_state_t st_reg;
  rcf_lc_state_t st_next;

  // ------------------------------------------------------------
  // Classification
  // ------------------------------------------------------------
  // Strictly greater than the limit counts as long
  always_comb begin
    st_next = st_reg;
    st_next.valid = eof_i;
    if (eof_i) begin
      st_next.long_frm = byte_count_i > max_len_i; // [R09]
      if (byte_count_i <= max_len_i) begin
        st_next.cls = RCF_CLS_OK;
      end else if (err_i) begin
        st_next.cls = RCF_CLS_JABBER; // [R11]
      end else begin
        st_next.cls = RCF_CLS_OVERSIZE; // [R10]
      end
    end
  end

  // State register
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      st_reg <= '{valid: 1'b0, long_frm: 1'b0, cls: RCF_CLS_OK};
    end else begin
      st_reg <= st_next;
    end
  end

  assign valid_o = st_reg.valid;
  assign long_o = st_reg.long_frm;
  assign class_o = st_reg.cls;

  a_long_class: assert property ( // [R09]
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    eof_i |=> (long_o == ($past(byte_count_i) > $past(max_len_i))))
    else $error("long flag does not match length compare");

  a_jabber_err: assert property ( // [R11]
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    eof_i && err_i && (byte_count_i > max_len_i)
      |=> valid_o && class_o == RCF_CLS_JABBER)
    else $error("long errored frame not jabber");

  a_oversize_ok: assert property ( // [R10]
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    eof_i && !err_i && (byte_count_i > max_len_i)
      |=> class_o == RCF_CLS_OVERSIZE)
    else $error("long clean frame not oversized");

endmodule
`default_nettype wire

// File: rcf_phy_model.sv
// Frame source model standing in for the receive front end.
// Assumes the filter samples frame strobes on the rising clock edge.
`timescale 1ns/1ps
`default_nettype none
module rcf_phy_model (
  input wire logic clk_i,
  output logic route_o,
  output logic unicast_o,
  output logic [2:0] uni_chan_o,
  output logic mcast_match_o,
  output logic eof_o,
  output logic [15:0] byte_count_o,
  output logic err_o
);
  // Idle: strobes low, qualifiers hold a pattern the filter must ignore
  initial begin
    {route_o, unicast_o, uni_chan_o, mcast_match_o} = 6'h15;
    {eof_o, byte_count_o, err_o} = 18'h0AAAA;
  end

  // Qualifiers are only meaningful with the strobe, so scramble them after
  task automatic route(input logic uni, input logic [2:0] ch,
                       input logic mc);
    @(posedge clk_i);
    route_o <= 1'b1;
    unicast_o <= uni;
    uni_chan_o <= ch;
    mcast_match_o <= mc;
    @(posedge clk_i);
    route_o <= 1'b0;
    unicast_o <= ~uni;
    uni_chan_o <= ~ch;
    mcast_match_o <= ~mc;
  endtask

  // End of frame with the final byte count and error flag
  task automatic frame_end(input logic [15:0] cnt, input logic err);
    @(posedge clk_i);
    eof_o <= 1'b1;
    byte_count_o <= cnt;
    err_o <= err;
    @(posedge clk_i);
    eof_o <= 1'b0;
    byte_count_o <= ~cnt;
    err_o <= ~err;
  endtask
endmodule
`default_nettype wire

// File: rcf_pkg.sv
// Package for the receive channel filter and frame length checker.
// Assumes a 32-bit register port with byte offsets; single clock domain.
package rcf_pkg;

  // ------------------------------------------------------------
  // Register map (byte offsets)
  // ------------------------------------------------------------
  localparam logic [7:0] RCF_OFS_MBP_ENABLE = 8'h00;
  localparam logic [7:0] RCF_OFS_UNI_SET = 8'h04;
  localparam logic [7:0] RCF_OFS_UNI_CLEAR = 8'h08;
  localparam logic [7:0] RCF_OFS_MAX_LEN = 8'h0C;
  localparam logic [7:0] RCF_OFS_INT_STATUS = 8'h10;
  localparam logic [7:0] RCF_OFS_INT_MASK = 8'h14;

  // ------------------------------------------------------------
  // Field positions and reset values
  // ------------------------------------------------------------
  localparam int RCF_MULT_CH_LSB = 0;
  localparam int RCF_MULT_EN_BIT = 5;
  localparam int RCF_NUM_CHAN = 8;
  localparam logic [15:0] RCF_MAX_LEN_RST = 16'h05EE;
  localparam logic [7:0] RCF_UNI_EN_RST = 8'h00;
  localparam logic [2:0] RCF_MULT_CH_RST = 3'h0;

  // Interrupt status bit positions
  localparam int RCF_EV_LONG = 0;
  localparam int RCF_EV_OVERSIZE = 1;
  localparam int RCF_EV_JABBER = 2;
  localparam int RCF_EV_DROP = 3;
  localparam int RCF_EV_W = 4;

  // Frame classes
  typedef enum logic [1:0] {
    RCF_CLS_OK = 2'h0,
    RCF_CLS_OVERSIZE = 2'h1,
    RCF_CLS_JABBER = 2'h2
  } rcf_class_t;

endpackage

// File: rcf_top.sv
// Receive channel filter and frame length checker, top level.
// Assumes a same-clock frame parser feeding the frame strobes and
// a one-cycle register port master; one clock, synchronous reset.
//
// Overview of operation
// (R01) Multicast channel field picks receive channel
// (R02) Multicast copied only while enable is set
// (R03) One unicast enable bit per channel
// (R04) Write one to set enables unicast
// (R05) Set register reads current unicast enables
// (R06) Write one to clear disables unicast
// (R07) Enables reset zero, upper bits read zero
// (R08) Max length 16 bits, resets to 1518
// (R09) Longer than maximum is long frame
// (R10) Long frame without error is oversized
// (R11) Long frame with error is jabber
// (R12) Unicast delivered only to enabled channel
// (R13) Clear register reads same enable state
`timescale 1ns/1ps
`default_nettype none
module rcf_top #(
  parameter int NUM_CHAN = 8
) (
  input wire logic CLK_SYS_I,
  input wire logic RSTN_I,
  input wire logic [7:0] ADDR_I,
  input wire logic [31:0] WDATA_I,
  input wire logic WR_I,
  input wire logic RD_I,
  output logic [31:0] RDATA_O,
  input wire logic FRM_ROUTE_I,
  input wire logic FRM_UNICAST_I,
  input wire logic [2:0] FRM_UNI_CHAN_I,
  input wire logic FRM_MCAST_MATCH_I,
  input wire logic FRM_EOF_I,
  input wire logic [15:0] FRM_BYTE_COUNT_I,
  input wire logic FRM_ERR_I,
  output logic [NUM_CHAN-1:0] DELIVER_O,
  output logic DROP_O,
  output logic CLASS_VALID_O,
  output logic LONG_O,
  output rcf_pkg::rcf_class_t CLASS_O,
  output logic IRQ_O
);
  import rcf_pkg::*;

  // Only eight enable bits exist, so other widths are refused
  if (NUM_CHAN != RCF_NUM_CHAN) begin : g_bad_chan
    $error("NUM_CHAN must equal eight unicast enable bits");
  end

  // ------------------------------------------------------------
  // State
  // ------------------------------------------------------------
  typedef struct packed {
    logic [2:0] mult_ch;
    logic mult_en;
    logic [7:0] uni_en;
    logic [15:0] max_len;
    logic [RCF_EV_W-1:0] int_stat;
    logic [RCF_EV_W-1:0] int_mask;
    logic [31:0] rdata;
  } rcf_state_t;

  rcf_state_t st_reg;
  rcf_state_t st_next;

  logic cls_valid;
  logic cls_long;
  rcf_class_t cls;
  logic [NUM_CHAN-1:0] deliver;
  logic drop;
  logic [RCF_EV_W-1:0] events;

  // Zero-extend a narrow field into a bus word
  function automatic logic [31:0] word8(input logic [7:0] v);
    word8 = {24'h000000, v};
  endfunction

  // Status read decode, shared by the clear logic and its checks
  function automatic logic stat_read(input logic rd, input logic [7:0] a);
    stat_read = rd && (a == RCF_OFS_INT_STATUS);
  endfunction

  // ------------------------------------------------------------
  // Sub-blocks
  // ------------------------------------------------------------
  rcf_chan_route #(
    .NUM_CHAN(NUM_CHAN)
  ) u_route (
    .CLK_SYS_I(CLK_SYS_I),
    .RSTN_I(RSTN_I),
    .route_i(FRM_ROUTE_I),
    .is_unicast_i(FRM_UNICAST_I),
    .uni_chan_i(FRM_UNI_CHAN_I),
    .is_mcast_match_i(FRM_MCAST_MATCH_I),
    .uni_en_i(st_reg.uni_en),
    .mult_ch_i(st_reg.mult_ch),
    .mult_en_i(st_reg.mult_en),
    .deliver_o(deliver),
    .drop_o(drop)
  );

  rcf_len_class u_len (
    .CLK_SYS_I(CLK_SYS_I),
    .RSTN_I(RSTN_I),
    .eof_i(FRM_EOF_I),
    .byte_count_i(FRM_BYTE_COUNT_I),
    .err_i(FRM_ERR_I),
    .max_len_i(st_reg.max_len),
    .valid_o(cls_valid),
    .long_o(cls_long),
    .class_o(cls)
  );

  // Events from the registered classifier and router outputs
  always_comb begin
    events = '0;
    events[RCF_EV_LONG] = cls_valid && cls_long;
    events[RCF_EV_OVERSIZE] = cls_valid && (cls == RCF_CLS_OVERSIZE);
    events[RCF_EV_JABBER] = cls_valid && (cls == RCF_CLS_JABBER);
    events[RCF_EV_DROP] = drop;
  end

  // ------------------------------------------------------------
  // Register writes, reads and interrupt status
  // ------------------------------------------------------------
  always_comb begin
    st_next = st_reg;
    st_next.rdata = 32'h0000_0000;
    if (WR_I) begin
      case (ADDR_I)
        RCF_OFS_MBP_ENABLE: begin
          st_next.mult_ch = WDATA_I[RCF_MULT_CH_LSB +: 3]; // [R01]
          st_next.mult_en = WDATA_I[RCF_MULT_EN_BIT]; // [R02]
        end
        RCF_OFS_UNI_SET: begin
          st_next.uni_en = st_reg.uni_en | WDATA_I[7:0]; // [R03] [R04]
        end
        RCF_OFS_UNI_CLEAR: begin
          st_next.uni_en = st_reg.uni_en & ~WDATA_I[7:0]; // [R03] [R06]
        end
        RCF_OFS_MAX_LEN: begin
          st_next.max_len = WDATA_I[15:0]; // [R08]
        end
        RCF_OFS_INT_MASK: begin
          st_next.int_mask = WDATA_I[RCF_EV_W-1:0];
        end
        default: begin
          st_next.int_mask = st_reg.int_mask;
        end
      endcase
    end
    if (RD_I) begin
      case (ADDR_I)
        RCF_OFS_MBP_ENABLE: begin
          st_next.rdata = word8({2'h0, st_reg.mult_en, 2'h0, st_reg.mult_ch});
        end
        // Both addresses show the live enables, upper bits zero
        RCF_OFS_UNI_SET: begin
          st_next.rdata = word8(st_reg.uni_en); // [R05] [R07]
        end
        RCF_OFS_UNI_CLEAR: begin
          st_next.rdata = word8(st_reg.uni_en); // [R13] [R07]
        end
        RCF_OFS_MAX_LEN: begin
          st_next.rdata = {16'h0000, st_reg.max_len}; // [R08]
        end
        RCF_OFS_INT_STATUS: begin
          st_next.rdata = {28'h0000000, st_reg.int_stat};
        end
        RCF_OFS_INT_MASK: begin
          st_next.rdata = {28'h0000000, st_reg.int_mask};
        end
        default: begin
          st_next.rdata = 32'h0000_0000;
        end
      endcase
    end
    // Read clears status; a new event in the same cycle still sticks
    if (stat_read(RD_I, ADDR_I)) begin
      st_next.int_stat = events;
    end else begin
      st_next.int_stat = st_reg.int_stat | events;
    end
  end

  // State register; enables and length take their reset values
  always_ff @(posedge CLK_SYS_I) begin
    if (!RSTN_I) begin
      st_reg.mult_ch <= RCF_MULT_CH_RST;
      st_reg.mult_en <= 1'b0;
      st_reg.uni_en <= RCF_UNI_EN_RST; // [R07]
      st_reg.max_len <= RCF_MAX_LEN_RST; // [R08]
      st_reg.int_stat <= '0;
      st_reg.int_mask <= '0;
      st_reg.rdata <= 32'h0000_0000;
    end else begin
      st_reg <= st_next;
    end
  end

  // ------------------------------------------------------------
  // Outputs
  // ------------------------------------------------------------
  assign RDATA_O = st_reg.rdata;
  assign DELIVER_O = deliver;
  assign DROP_O = drop;
  assign CLASS_VALID_O = cls_valid;
  assign LONG_O = cls_long;
  assign CLASS_O = cls;
  // Level output: held until software reads status
  assign IRQ_O = |(st_reg.int_stat & st_reg.int_mask);

  // ------------------------------------------------------------
  // Checks
  // ------------------------------------------------------------
  a_uni_set_bits: assert property ( // [R04]
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    WR_I && ADDR_I == RCF_OFS_UNI_SET
      |=> st_reg.uni_en == ($past(st_reg.uni_en) | $past(WDATA_I[7:0])))
    else $error("unicast set write wrong");

  a_uni_clr_bits: assert property ( // [R06]
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    WR_I && ADDR_I == RCF_OFS_UNI_CLEAR
      |=> st_reg.uni_en == ($past(st_reg.uni_en) & ~$past(WDATA_I[7:0])))
    else $error("unicast clear write wrong");

  a_uni_readback: assert property ( // [R05] [R13]
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    RD_I && (ADDR_I == RCF_OFS_UNI_SET || ADDR_I == RCF_OFS_UNI_CLEAR)
      |=> RDATA_O == {24'h000000, $past(st_reg.uni_en)})
    else $error("unicast readback wrong");

  a_reset_vals: assert property ( // [R07]
    @(posedge CLK_SYS_I)
    !RSTN_I |=> st_reg.uni_en == 8'h00 && st_reg.max_len == 16'h05EE)
    else $error("reset values wrong");

  a_maxlen_rd: assert property ( // [R08]
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    RD_I && ADDR_I == RCF_OFS_MAX_LEN |=> RDATA_O[31:16] == 16'h0000)
    else $error("max length upper bits not zero");

  // Other accesses must leave the unicast enables alone
  a_uni_en_hold: assert property ( // [R04] [R06]
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    !(WR_I && (ADDR_I == RCF_OFS_UNI_SET || ADDR_I == RCF_OFS_UNI_CLEAR))
      |=> $stable(st_reg.uni_en))
    else $error("unicast enables changed without write");

  // Length register takes the low half word, upper half ignored
  a_maxlen_wr: assert property ( // [R08]
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    WR_I && ADDR_I == RCF_OFS_MAX_LEN
      |=> st_reg.max_len == $past(WDATA_I[15:0]))
    else $error("max length write wrong");

  // Length readback shows the live limit
  a_maxlen_rdata: assert property ( // [R08]
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    RD_I && ADDR_I == RCF_OFS_MAX_LEN
      |=> RDATA_O[15:0] == $past(st_reg.max_len))
    else $error("max length readback wrong");

  // Channel field and enable bit land in their own fields
  a_mcast_wr: assert property ( // [R01] [R02]
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    WR_I && ADDR_I == RCF_OFS_MBP_ENABLE
      |=> st_reg.mult_ch == $past(WDATA_I[2:0])
        && st_reg.mult_en == $past(WDATA_I[RCF_MULT_EN_BIT]))
    else $error("multicast select write wrong");

  // ------------------------------------------------------------
  // Status, read data and interrupt checks
  // ------------------------------------------------------------
  // An event in the read-clear cycle must still be recorded
  a_stat_sticky: assert property (
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    (|events) |=> (st_reg.int_stat & $past(events)) == $past(events))
    else $error("status event lost");

  // Reading status leaves only what arrived in that cycle
  a_stat_rd_clr: assert property (
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    stat_read(RD_I, ADDR_I) |=> st_reg.int_stat == $past(events))
    else $error("status not cleared by read");

  // Without a status read, bits only accumulate
  a_stat_hold: assert property (
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    !stat_read(RD_I, ADDR_I)
      |=> st_reg.int_stat == ($past(st_reg.int_stat) | $past(events)))
    else $error("status changed without read");

  // Read data stand for one cycle only, zero otherwise
  a_rdata_idle: assert property (
    @(posedge CLK_SYS_I) disable iff (!RSTN_I)
    !RD_I |=> RDATA_O == 32'h0000_0000)
    else $error("read data not zero without read");

  // Reset leaves no pending interrupt and no stale read data
  a_rst_outputs: assert property (
    @(posedge CLK_SYS_I)
    !RSTN_I |=> !IRQ_O && RDATA_O == 32'h0000_0000)
    else $error("interrupt or read data set after reset");

endmodule
`default_nettype wire

// File: rcf_top_tb_top.sv
// Self-checking bench for the receive channel filter.
// Assumes the frame source model and the one-cycle register port.
`timescale 1ns/1ps
`default_nettype none
module rcf_top_tb_top;
  import rcf_pkg::*;
  logic clk, rstn, wr, rd;
  logic [7:0] addr, deliver;
  logic [31:0] wdata, rdata;
  logic f_route, f_uni, f_mc, f_eof, f_err, drop, cvalid, long_f, irq;
  logic [2:0] f_ch;
  logic [15:0] f_cnt;
  rcf_class_t cls_o;
  int n_mismatch = 0;
  int checked = 0;

  // ------------------------------------------------------------
  // Clock, design and frame source
  // ------------------------------------------------------------
  initial clk = 1'b0;
  always #2.5 clk = ~clk;

  rcf_top #(.NUM_CHAN(8)) i_dut (
    .CLK_SYS_I(clk), .RSTN_I(rstn), .ADDR_I(addr), .WDATA_I(wdata),
    .WR_I(wr), .RD_I(rd), .RDATA_O(rdata), .FRM_ROUTE_I(f_route),
    .FRM_UNICAST_I(f_uni), .FRM_UNI_CHAN_I(f_ch),
    .FRM_MCAST_MATCH_I(f_mc), .FRM_EOF_I(f_eof),
    .FRM_BYTE_COUNT_I(f_cnt), .FRM_ERR_I(f_err), .DELIVER_O(deliver),
    .DROP_O(drop), .CLASS_VALID_O(cvalid), .LONG_O(long_f),
    .CLASS_O(cls_o), .IRQ_O(irq)
  );

  rcf_phy_model i_phy (
    .clk_i(clk), .route_o(f_route), .unicast_o(f_uni),
    .uni_chan_o(f_ch), .mcast_match_o(f_mc), .eof_o(f_eof),
    .byte_count_o(f_cnt), .err_o(f_err)
  );

  // ------------------------------------------------------------
  // Access and compare tasks
  // ------------------------------------------------------------
  task automatic check(input string nm, input logic [31:0] got,
                       input logic [31:0] exp);
    checked++;
    if (got !== exp) begin
      n_mismatch++;
      $display("[FAIL] %s expected %0h seen %0h", nm, exp, got);
    end
  endtask

  task automatic wr_reg(input logic [7:0] a, input logic [31:0] d);
    @(posedge clk);
    wr <= 1'b1;
    addr <= a;
    wdata <= d;
    @(posedge clk);
    wr <= 1'b0;
  endtask

  // Read data stand only in the cycle after the strobe
  task automatic rd_chk(input logic [7:0] a, input logic [31:0] exp,
                        input string nm);
    @(posedge clk);
    rd <= 1'b1;
    addr <= a;
    @(posedge clk);
    rd <= 1'b0;
    #1;
    check(nm, rdata, exp);
    @(posedge clk);
    #1;
    check("rdata_idle", rdata, 32'h0);
  endtask

  task automatic route(input logic uni, input logic [2:0] ch,
                       input logic mc, input logic [7:0] exp);
    i_phy.route(uni, ch, mc);
    #1;
    check("deliver", 32'(deliver), 32'(exp));
    check("drop", 32'(drop), 32'(exp == 8'h00));
    @(posedge clk);
    #1;
    check("deliver_end", 32'(deliver), 32'h0);
    check("drop_end", 32'(drop), 32'h0);
  endtask

  task automatic cls(input logic [15:0] n, input logic err,
                     input logic lg, input rcf_class_t c);
    i_phy.frame_end(n, err);
    #1;
    check("class_valid", 32'(cvalid), 32'h1);
    check("long", 32'(long_f), 32'(lg));
    check("class", 32'(cls_o), 32'(c));
    @(posedge clk);
    #1;
    check("class_valid_end", 32'(cvalid), 32'h0);
    check("class_hold", 32'(cls_o), 32'(c));
  endtask

  task automatic irq_chk(input logic exp);
    @(posedge clk);
    #1;
    check("irq", 32'(irq), 32'(exp));
  endtask

  task automatic print_verdict();
    $display("checks %0d mismatches %0d", checked, n_mismatch);
    if (n_mismatch == 0 && checked > 0) begin
      $display("*** PASS ***");
    end else begin
      $display("*** FAIL ***");
    end
    $finish;
  endtask

  // ------------------------------------------------------------
  // Test sequence
  // ------------------------------------------------------------
  initial begin
    {rstn, wr, rd, addr, wdata} = '0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    rd_chk(8'h04, 32'h0, "uni_set_rst");
    rd_chk(8'h08, 32'h0, "uni_clr_rst");
    rd_chk(8'h0C, 32'h5EE, "max_len_rst");
    rd_chk(8'h3C, 32'h0, "unmapped");
    cls(16'd1518, 1'b0, 1'b0, RCF_CLS_OK);
    cls(16'd1519, 1'b0, 1'b1, RCF_CLS_OVERSIZE);
    // Set, then zeros and reserved bits must change nothing
    wr_reg(8'h04, 32'hFFFF_FF05);
    wr_reg(8'h04, 32'h0000_0080);
    rd_chk(8'h04, 32'h85, "uni_set");
    wr_reg(8'h08, 32'hFFFF_FF01);
    wr_reg(8'h08, 32'h0);
    rd_chk(8'h04, 32'h84, "uni_after_clr");
    rd_chk(8'h08, 32'h84, "uni_clr_read");
    // Each channel gets unicast traffic only if its own bit is set
    for (int ch = 0; ch < 8; ch++) begin
      route(1'b1, ch[2:0], 1'b0,
            (ch == 2 || ch == 7) ? 8'h1 << ch : 8'h0);
    end
    // Every multicast channel code, then enable off and no match
    for (int ch = 0; ch < 8; ch++) begin
      wr_reg(8'h00, 32'h20 | ch);
      route(1'b0, ~ch[2:0], 1'b1, 8'h1 << ch);
    end
    route(1'b0, 3'h0, 1'b0, 8'h00);
    wr_reg(8'h00, 32'h03);
    rd_chk(8'h00, 32'h03, "mcast_sel");
    route(1'b0, 3'h0, 1'b1, 8'h00);
    // Small limit, boundary with and without errors
    wr_reg(8'h0C, 32'hABCD_0010);
    rd_chk(8'h0C, 32'h10, "max_len");
    cls(16'd16, 1'b1, 1'b0, RCF_CLS_OK);
    cls(16'd17, 1'b1, 1'b1, RCF_CLS_JABBER);
    cls(16'd17, 1'b0, 1'b1, RCF_CLS_OVERSIZE);
    // Sticky status, mask and read-to-clear
    rd_chk(8'h10, 32'hF, "status_all");
    cls(16'd17, 1'b0, 1'b1, RCF_CLS_OVERSIZE);
    irq_chk(1'b0);
    wr_reg(8'h14, 32'h2);
    #1;
    check("irq_unmasked", 32'(irq), 32'h1);
    rd_chk(8'h10, 32'h3, "status_long");
    check("irq_cleared", 32'(irq), 32'h0);
    wr_reg(8'h14, 32'h8);
    route(1'b1, 3'h0, 1'b0, 8'h00);
    irq_chk(1'b1);
    rd_chk(8'h10, 32'h8, "status_drop");
    // Status ignores writes; an unmapped write touches nothing
    wr_reg(8'h10, 32'hF);
    rd_chk(8'h10, 32'h0, "status_wr_ignored");
    wr_reg(8'h3C, 32'hFFFF_FFFF);
    rd_chk(8'h14, 32'h8, "mask");
    rd_chk(8'h0C, 32'h10, "max_len_kept");
    // Reset in mid-run with an interrupt pending
    route(1'b1, 3'h1, 1'b0, 8'h00);
    irq_chk(1'b1);
    @(posedge clk);
    rstn <= 1'b0;
    repeat (2) @(posedge clk);
    rstn <= 1'b1;
    irq_chk(1'b0);
    rd_chk(8'h04, 32'h0, "uni_set_rst2");
    rd_chk(8'h08, 32'h0, "uni_clr_rst2");
    rd_chk(8'h0C, 32'h5EE, "max_len_rst2");
    rd_chk(8'h00, 32'h0, "mcast_sel_rst");
    rd_chk(8'h14, 32'h0, "mask_rst");
    print_verdict();
  end

  // Watchdog: the sequence needs under two hundred cycles
  initial begin
    repeat (3000) @(posedge clk);
    n_mismatch++;
    print_verdict();
  end
endmodule
`default_nettype wire
